// File: rtl/aws_signaller.sv
// Alarm signaller: warning, fault escalation, output level, lamp and relay.
// Operation
// - Warning alternates error level with 10 V.
// - Warning blinks lamp, relay stays off.
// - START escalates warning to steady fault.
// - Codes 104-106, 302, 303 use 5.33 V.
// - Hot calibration temperature raises 115, 8.66 V.
// - Alternation toggles at 1 Hz.
// - Clear completes after clear bit returns low.
`timescale 1ns/1ps
module aws_signaller #(
  parameter logic [27:0] HALF_CYC = 28'(aws_pkg::HALF_PERIOD_CYC)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic err_valid,
  input wire logic [aws_pkg::CODE_W-1:0] err_code,
  input wire logic start,
  input wire logic error_clear_bit,
  input wire logic cal_request,
  input wire logic [aws_pkg::TEMP_W-1:0] cal_temp_c,
  input wire logic cal_temp_stable,
  output logic [aws_pkg::LEVEL_W-1:0] out_level,
  output logic alarm_lamp,
  output logic alarm_relay,
  output logic cal_blocked,
  output logic [aws_pkg::CODE_W-1:0] active_code
);
  aws_tick_if tk ();
  aws_pkg::aws_state_t state;
  aws_pkg::aws_state_t next_state;
  logic [aws_pkg::CODE_W-1:0] code;
  logic [aws_pkg::CODE_W-1:0] next_code;
  logic [aws_pkg::LEVEL_W-1:0] level;
  logic [aws_pkg::LEVEL_W-1:0] next_level;
  logic [aws_pkg::LEVEL_W-1:0] err_level;
  logic lamp;
  logic next_lamp;
  logic relay;
  logic next_relay;
  logic blocked;
  logic next_blocked;
  logic [aws_pkg::CODE_W-1:0] new_code;
  logic new_valid;
  logic new_blocked;
  logic [aws_pkg::CODE_W-1:0] lvl_code;
  logic seen_phase;
  logic next_seen_phase;
  logic [aws_pkg::TICK_W-1:0] hold_cnt;
  logic [aws_pkg::TICK_W-1:0] next_hold_cnt;

  aws_toggle_timer #(.HALF_CYC(HALF_CYC)) u_timer (
    .clk(clk),
    .rst(rst),
    .tk(tk.timer)
  );

  always_comb begin
    new_valid = err_valid;
    new_code = err_code;
    new_blocked = 1'b0;
    if (cal_request && cal_temp_c > aws_pkg::CAL_TEMP_MAX_C) begin
      new_valid = 1'b1;
      new_code = aws_pkg::CODE_115;
      new_blocked = 1'b1;
    end else if (cal_request && !cal_temp_stable) begin
      new_valid = 1'b1;
      new_code = aws_pkg::CODE_116;
      new_blocked = 1'b1;
    end
  end

  // A fresh error needs its level on the very edge that takes it, before code holds it.
  assign lvl_code = (state == aws_pkg::AWS_IDLE) ? new_code : code;

  always_comb begin
    case (lvl_code)
      aws_pkg::CODE_104, aws_pkg::CODE_105, aws_pkg::CODE_106,
      aws_pkg::CODE_302, aws_pkg::CODE_303: err_level = aws_pkg::LVL_SIGNAL_CAL;
      aws_pkg::CODE_211: err_level = aws_pkg::LVL_DATA_ERR;
      aws_pkg::CODE_111: err_level = aws_pkg::LVL_CUR_NOCAL;
      aws_pkg::CODE_112: err_level = aws_pkg::LVL_VOLT_NOCAL;
      aws_pkg::CODE_113, aws_pkg::CODE_114: err_level = aws_pkg::LVL_BOTH_NOCAL;
      aws_pkg::CODE_115, aws_pkg::CODE_116: err_level = aws_pkg::LVL_EXT_TEMP;
      default: err_level = aws_pkg::LVL_NONE;
    endcase
  end

  // Starting the count on the edge that enters warning keeps the first half as long as the others.
  assign tk.run = (next_state == aws_pkg::AWS_WARN);

  // The clear is held off while the bit stays high so a stuck bit cannot mask new errors half-way.
  always_comb begin
    next_state = state;
    next_code = code;
    next_level = aws_pkg::LVL_NONE;
    next_lamp = 1'b0;
    next_relay = 1'b0;
    next_blocked = blocked;
    case (state)
      aws_pkg::AWS_IDLE: begin
        if (new_valid) begin
          next_state = aws_pkg::AWS_WARN;
          next_code = new_code;
          next_blocked = new_blocked;
        end
      end
      aws_pkg::AWS_WARN: begin
        if (error_clear_bit) begin
          next_state = aws_pkg::AWS_CLEAR;
        end else if (start) begin
          next_state = aws_pkg::AWS_FAULT;
        end
      end
      aws_pkg::AWS_FAULT: begin
        if (error_clear_bit) begin
          next_state = aws_pkg::AWS_CLEAR;
        end
      end
      aws_pkg::AWS_CLEAR: begin
        if (!error_clear_bit) begin
          next_state = aws_pkg::AWS_IDLE;
          next_code = aws_pkg::CODE_NONE;
          next_blocked = 1'b0;
        end
      end
      default: next_state = aws_pkg::AWS_IDLE;
    endcase
    if (next_state == aws_pkg::AWS_WARN) begin
      next_level = tk.phase ? aws_pkg::LVL_END_SCALE : err_level;
      next_lamp = ~tk.phase;
      next_relay = 1'b0;
    end else if (next_state == aws_pkg::AWS_FAULT || next_state == aws_pkg::AWS_CLEAR) begin
      next_level = err_level;
      next_lamp = 1'b1;
      next_relay = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= aws_pkg::AWS_IDLE;
      code <= aws_pkg::CODE_NONE;
      level <= aws_pkg::LVL_NONE;
      lamp <= 1'b0;
      relay <= 1'b0;
      blocked <= 1'b0;
    end else begin
      state <= next_state;
      code <= next_code;
      level <= next_level;
      lamp <= next_lamp;
      relay <= next_relay;
      blocked <= next_blocked;
    end
  end

  always_comb begin
    next_seen_phase = tk.phase;
    next_hold_cnt = '0;
    if (tk.run && tk.phase == seen_phase) begin
      next_hold_cnt = hold_cnt + 28'h0000001;
    end else if (tk.run) begin
      next_hold_cnt = 28'h0000001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      seen_phase <= 1'b0;
      hold_cnt <= '0;
    end else begin
      seen_phase <= next_seen_phase;
      hold_cnt <= next_hold_cnt;
    end
  end

  assign out_level = level;
  assign alarm_lamp = lamp;
  assign alarm_relay = relay;
  assign cal_blocked = blocked;
  assign active_code = code;

  warn_relay_a: assert property (@(posedge clk) disable iff (rst)
    state == aws_pkg::AWS_WARN |=> !alarm_relay || state != aws_pkg::AWS_WARN)
    else $error("Relay energized during warning.");
  warn_level_a: assert property (@(posedge clk) disable iff (rst)
    state == aws_pkg::AWS_WARN && $past(state) == aws_pkg::AWS_WARN && tk.phase == $past(tk.phase)
    |-> out_level == (tk.phase ? aws_pkg::LVL_END_SCALE : err_level))
    else $error("Warning level wrong.");
  fault_steady_a: assert property (@(posedge clk) disable iff (rst)
    state == aws_pkg::AWS_WARN && start && !error_clear_bit
    |=> state == aws_pkg::AWS_FAULT ##1 alarm_lamp && alarm_relay && out_level == err_level)
    else $error("Fault outputs not steady.");
  shared_level_a: assert property (@(posedge clk) disable iff (rst)
    state == aws_pkg::AWS_FAULT && active_code == aws_pkg::CODE_302 |-> out_level == aws_pkg::LVL_SIGNAL_CAL)
    else $error("Code 302 level wrong.");
  hot_cal_a: assert property (@(posedge clk) disable iff (rst)
    state == aws_pkg::AWS_IDLE && cal_request && cal_temp_c > aws_pkg::CAL_TEMP_MAX_C
    |=> active_code == aws_pkg::CODE_115 && cal_blocked)
    else $error("Hot calibration not flagged.");
  unstable_cal_a: assert property (@(posedge clk) disable iff (rst)
    state == aws_pkg::AWS_IDLE && cal_request && cal_temp_c <= aws_pkg::CAL_TEMP_MAX_C && !cal_temp_stable
    |=> active_code == aws_pkg::CODE_116)
    else $error("Unstable calibration not flagged.");
  clear_hold_a: assert property (@(posedge clk) disable iff (rst)
    state == aws_pkg::AWS_CLEAR && error_clear_bit |=> state == aws_pkg::AWS_CLEAR)
    else $error("Clear finished with bit still set.");
  toggle_rate_a: assert property (@(posedge clk) disable iff (rst)
    $rose(tk.run) |-> !tk.phase [*8])
    else $error("Phase toggled too soon.");
  cover_warn_c: cover property (@(posedge clk) state == aws_pkg::AWS_WARN);
  cover_fault_c: cover property (@(posedge clk) state == aws_pkg::AWS_FAULT);
  cover_clear_c: cover property (@(posedge clk) state == aws_pkg::AWS_CLEAR ##1 state == aws_pkg::AWS_IDLE);
  phase_hold_a: assert property (@(posedge clk) disable iff (rst)
    tk.run && tk.phase != seen_phase |-> hold_cnt == HALF_CYC)
    else $error("Phase half period wrong.");
  phase_max_a: assert property (@(posedge clk) disable iff (rst)
    tk.run |-> hold_cnt <= HALF_CYC)
    else $error("Phase held too long.");
  warn_lamp_a: assert property (@(posedge clk) disable iff (rst)
    state == aws_pkg::AWS_WARN && $past(state) == aws_pkg::AWS_WARN && tk.phase == $past(tk.phase)
    |-> alarm_lamp == !tk.phase)
    else $error("Lamp not blinking with phase.");
  clear_done_a: assert property (@(posedge clk) disable iff (rst)
    state == aws_pkg::AWS_CLEAR && !error_clear_bit
    |=> state == aws_pkg::AWS_IDLE && active_code == aws_pkg::CODE_NONE && !alarm_lamp && !alarm_relay
    && out_level == aws_pkg::LVL_NONE)
    else $error("Clear did not release outputs.");
  err_noblock_a: assert property (@(posedge clk) disable iff (rst)
    state == aws_pkg::AWS_IDLE && err_valid && !cal_request |=> !cal_blocked)
    else $error("Calibration blocked by plain error.");
  cover_toggle_c: cover property (@(posedge clk) tk.run && tk.phase != seen_phase);
  cover_cal_block_c: cover property (@(posedge clk) state == aws_pkg::AWS_WARN && cal_blocked);
endmodule

// File: rtl/aws_pkg.sv
// Package with codes, levels and timing constants of the alarm signaller.
package aws_pkg;
  localparam int CODE_W = 10;
  localparam int LEVEL_W = 10;
  // Output level in hundredths of a volt.
  localparam logic [LEVEL_W-1:0] LVL_END_SCALE = 10'h3E8;
  localparam logic [LEVEL_W-1:0] LVL_SIGNAL_CAL = 10'h215;
  localparam logic [LEVEL_W-1:0] LVL_DATA_ERR = 10'h258;
  localparam logic [LEVEL_W-1:0] LVL_CUR_NOCAL = 10'h29A;
  localparam logic [LEVEL_W-1:0] LVL_VOLT_NOCAL = 10'h2DD;
  localparam logic [LEVEL_W-1:0] LVL_BOTH_NOCAL = 10'h320;
  localparam logic [LEVEL_W-1:0] LVL_EXT_TEMP = 10'h362;
  localparam logic [LEVEL_W-1:0] LVL_NONE = 10'h000;
  localparam logic [CODE_W-1:0] CODE_NONE = 10'h000;
  localparam logic [CODE_W-1:0] CODE_104 = 10'h068;
  localparam logic [CODE_W-1:0] CODE_105 = 10'h069;
  localparam logic [CODE_W-1:0] CODE_106 = 10'h06A;
  localparam logic [CODE_W-1:0] CODE_111 = 10'h06F;
  localparam logic [CODE_W-1:0] CODE_112 = 10'h070;
  localparam logic [CODE_W-1:0] CODE_113 = 10'h071;
  localparam logic [CODE_W-1:0] CODE_114 = 10'h072;
  localparam logic [CODE_W-1:0] CODE_115 = 10'h073;
  localparam logic [CODE_W-1:0] CODE_116 = 10'h074;
  localparam logic [CODE_W-1:0] CODE_211 = 10'h0D3;
  localparam logic [CODE_W-1:0] CODE_302 = 10'h12E;
  localparam logic [CODE_W-1:0] CODE_303 = 10'h12F;
  localparam int TEMP_W = 8;
  localparam logic [TEMP_W-1:0] CAL_TEMP_MAX_C = 8'h28;
  localparam longint CLK_HZ = 200000000;
  localparam longint TOGGLE_HZ = 1;
  localparam longint HALF_PERIOD_CYC = CLK_HZ / (2 * TOGGLE_HZ);
  localparam int TICK_W = 28;
  typedef enum logic [1:0] {AWS_IDLE, AWS_WARN, AWS_FAULT, AWS_CLEAR} aws_state_t;
endpackage

// File: rtl/aws_tick_if.sv
// Interface carrying the toggle tick between the alarm core and its timer.
`timescale 1ns/1ps
interface aws_tick_if;
  logic run;
  logic phase;
  modport timer (input run, output phase);
  modport core (output run, input phase);
endinterface

// File: rtl/aws_toggle_timer.sv
// Half-period timer producing the 1 Hz alternation phase.
`timescale 1ns/1ps
module aws_toggle_timer #(
  parameter logic [27:0] HALF_CYC = 28'(aws_pkg::HALF_PERIOD_CYC)
) (
  input wire logic clk,
  input wire logic rst,
  aws_tick_if.timer tk
);
  logic [aws_pkg::TICK_W-1:0] cnt;
  logic [aws_pkg::TICK_W-1:0] next_cnt;
  logic phase;
  logic next_phase;

  always_comb begin
    next_cnt = cnt;
    next_phase = phase;
    if (!tk.run) begin
      next_cnt = '0;
      next_phase = 1'b0;
    end else if (cnt == HALF_CYC - 28'h0000001) begin
      next_cnt = '0;
      next_phase = ~phase;
    end else begin
      next_cnt = cnt + 28'h0000001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= '0;
      phase <= 1'b0;
    end else begin
      cnt <= next_cnt;
      phase <= next_phase;
    end
  end

  assign tk.phase = phase;
endmodule

// File: sim/aws_ctrl_model.sv
// Machine controller model that drives START and the clear bit.
`timescale 1ns/1ps
module aws_ctrl_model (
  input wire logic clk,
  output logic start,
  output logic error_clear_bit
);
  initial begin
    start = 1'b0;
    error_clear_bit = 1'b0;
  end
  // drive start and clear.
  // Levels change only after a falling edge, so the device never sees them move at its sampling edge.
  task automatic drive(input logic s, input logic c);
    @(negedge clk);
    start = s;
    error_clear_bit = c;
  endtask
endmodule

// File: sim/aws_signaller_test.sv
// Self-checking bench of the alarm signaller.
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; $display("Error at %0t: got %h exp %h", $time, (a), (e)); end end
module aws_signaller_test;
  localparam logic [27:0] HC = 28'h0000010;
  localparam logic [9:0] LE = aws_pkg::LVL_END_SCALE;
  localparam logic [9:0] LS = aws_pkg::LVL_SIGNAL_CAL;
  localparam logic [9:0] LT = aws_pkg::LVL_EXT_TEMP;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic err_valid = 1'b0;
  logic cal_request = 1'b0;
  logic cal_temp_stable = 1'b1;
  logic [9:0] err_code = 10'h000;
  logic [7:0] cal_temp_c = 8'h00;
  logic start, error_clear_bit, alarm_lamp, alarm_relay, cal_blocked;
  logic [9:0] out_level, active_code;
  int miscompares = 0;
  int checks_done = 0;
  int n;
  aws_signaller #(.HALF_CYC(HC)) aws_signaller_inst (.clk(clk), .rst(rst), .err_valid(err_valid),
    .err_code(err_code), .start(start), .error_clear_bit(error_clear_bit), .cal_request(cal_request),
    .cal_temp_c(cal_temp_c), .cal_temp_stable(cal_temp_stable), .out_level(out_level),
    .alarm_lamp(alarm_lamp), .alarm_relay(alarm_relay), .cal_blocked(cal_blocked), .active_code(active_code));
  aws_ctrl_model aws_ctrl_model_inst (.clk(clk), .start(start), .error_clear_bit(error_clear_bit));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic tally_and_finish;
    $display("Checks %0d, miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic expect_out(input logic [9:0] c, input logic [9:0] l, input logic lp, input logic rl);
    `CHK({active_code, out_level, alarm_lamp, alarm_relay}, {c, l, lp, rl})
  endtask
  task automatic raise(input logic [9:0] c);
    @(negedge clk);
    err_valid = 1'b1;
    err_code = c;
    @(negedge clk);
    err_valid = 1'b0;
  endtask
  // Bounded so that a level that never toggles cannot hang the run.
  task automatic wait_change(output int k);
    logic [9:0] was;
    was = out_level;
    k = 0;
    while (out_level === was && k <= int'(HC) + 3) begin
      @(negedge clk);
      k++;
    end
  endtask
  task automatic test_warn_fault(input logic [9:0] c, input logic [9:0] l);
    raise(c);
    expect_out(c, l, 1'b1, 1'b0);
    wait_change(n);
    `CHK(n, int'(HC))
    expect_out(c, LE, 1'b0, 1'b0);
    wait_change(n);
    `CHK(n, int'(HC))
    expect_out(c, l, 1'b1, 1'b0);
    aws_ctrl_model_inst.drive(1'b1, 1'b0);
    @(negedge clk);
    expect_out(c, l, 1'b1, 1'b1);
    raise(aws_pkg::CODE_211);
    repeat (2 * HC) @(negedge clk);
    expect_out(c, l, 1'b1, 1'b1);
    aws_ctrl_model_inst.drive(1'b0, 1'b1);
    repeat (4) @(negedge clk);
    expect_out(c, l, 1'b1, 1'b1);
    aws_ctrl_model_inst.drive(1'b0, 1'b0);
    @(negedge clk);
    expect_out(10'h000, 10'h000, 1'b0, 1'b0);
    $display("Warning and fault test done, code %h", c);
  endtask
  task automatic test_cal(input logic [7:0] t, input logic s, input logic [9:0] c, input logic [9:0] l);
    @(negedge clk);
    cal_request = 1'b1;
    cal_temp_c = t;
    cal_temp_stable = s;
    @(negedge clk);
    cal_request = 1'b0;
    expect_out(c, l, c !== 10'h000, 1'b0);
    `CHK(cal_blocked, c !== 10'h000)
    aws_ctrl_model_inst.drive(1'b0, 1'b1);
    aws_ctrl_model_inst.drive(1'b0, 1'b0);
    @(negedge clk);
    expect_out(10'h000, 10'h000, 1'b0, 1'b0);
    $display("Calibration test done, temp %h", t);
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    test_warn_fault(aws_pkg::CODE_104, LS);
    test_warn_fault(aws_pkg::CODE_105, LS);
    test_warn_fault(aws_pkg::CODE_106, LS);
    test_warn_fault(aws_pkg::CODE_302, LS);
    test_warn_fault(aws_pkg::CODE_303, LS);
    test_warn_fault(aws_pkg::CODE_211, aws_pkg::LVL_DATA_ERR);
    test_warn_fault(aws_pkg::CODE_111, aws_pkg::LVL_CUR_NOCAL);
    test_warn_fault(aws_pkg::CODE_112, aws_pkg::LVL_VOLT_NOCAL);
    test_warn_fault(aws_pkg::CODE_113, aws_pkg::LVL_BOTH_NOCAL);
    test_warn_fault(aws_pkg::CODE_114, aws_pkg::LVL_BOTH_NOCAL);
    test_cal(8'h29, 1'b1, aws_pkg::CODE_115, LT);
    test_cal(8'h28, 1'b0, aws_pkg::CODE_116, LT);
    test_cal(8'h28, 1'b1, 10'h000, 10'h000);
    tally_and_finish;
  end
  // The tests need about 800 cycles; this limit leaves a wide margin.
  initial begin
    repeat (4000) @(posedge clk);
    miscompares++;
    tally_and_finish;
  end
endmodule
